// >>> bench/escfg_regs_sva.sv
`timescale 1ns/1ps
module escfg_regs_sva
  import escfg_pkg::*;
#(
  parameter int AW = 9
)(
  // clock and reset
  input wire logic          mclk,
  input wire logic          resetn,
  // bus
  input wire logic [AW-1:0] address,
  input wire logic          read,
  input wire logic          write,
  input wire logic [31:0]   readdata,
  input wire logic          waitrequest,
  input wire logic [1:0]    response,
  // scanner side
  input wire logic          scanDone,
  input wire logic [31:0]   pointTime_ff,
  input wire logic [31:0]   pointBudget_ff,
  input wire logic [15:0]   errorThresh_ff,
  input wire logic [7:0]    sliceLevel_ff,
  input wire logic          scanActive_ff,
  input wire logic [2:0]    patternRate_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // decode window; one word per index, so the low two address bits never matter
  wire logic hit = address[8:2] >= 7'h52 && address[8:2] <= 7'h5E;
  wire logic done = (read || write) && !waitrequest;

  a_wait_single: assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
  a_resp_ok: assert property (done && hit |-> response == 2'h0) else $error("bad ok response");
  a_decode_error: assert property (done && !hit |-> response == 2'h3) else $error("no decode error");
  a_unmapped_zero: assert property (read && done && !hit |-> readdata == 32'h0) else $error("unmapped data");
  a_upper_zero: assert property (readdata[31:16] == 16'h0000) else $error("upper half set");
  a_budget_double: assert property (pointBudget_ff == {pointTime_ff[30:0], 1'b0}) else $error("budget");
  a_reset_defaults: assert property ($rose(resetn) |-> pointTime_ff == 32'h64 &&
    errorThresh_ff == 16'h64 && sliceLevel_ff == 8'h80 && patternRate_ff == 3'h6) else $error("defaults");
  a_snapshot_hold: assert property (scanActive_ff && $past(scanActive_ff) |->
    $stable(pointTime_ff) && $stable(errorThresh_ff) && $stable(sliceLevel_ff)) else $error("snapshot moved");
  a_scan_end: assert property (scanActive_ff && scanDone |=> !scanActive_ff) else $error("scan kept");
endmodule
bind escfg_regs escfg_regs_sva #(.AW(AW)) i_escfg_regs_sva (.mclk(mclk), .resetn(resetn), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .response(response),
  .scanDone(scanDone), .pointTime_ff(pointTime_ff), .pointBudget_ff(pointBudget_ff),
  .errorThresh_ff(errorThresh_ff), .sliceLevel_ff(sliceLevel_ff), .scanActive_ff(scanActive_ff),
  .patternRate_ff(patternRate_ff));

// >>> bench/escfg_regs_tb_top.sv
`timescale 1ns/1ps
module escfg_regs_tb_top;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [8:0]  address = 9'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [2:0]  cdrRate = 3'h0;
  logic        scanDone = 1'b0;
  logic [31:0] readdata, pointTime, pointBudget;
  logic [15:0] errorThresh;
  logic [7:0]  sliceLevel, voltageLimit;
  logic [6:0]  phaseBegin, phaseLimit, phaseStep, voltageBegin;
  logic [1:0]  response;
  logic [2:0]  patternRate;
  logic        waitrequest, shapeMode, scanActive, scannerInit, scannerPower;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          n_fail = 0;
  int          cmp_count = 0;
  // reset table of the mapped words 7'h52 through 7'h5B
  logic [6:0]  rIdx [10] = '{7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5A, 7'h5B};
  logic [15:0] rVal [10] = '{16'h0106, 16'h0, 16'h0, 16'h64, 16'h64, 16'h8002, 16'hD982, 16'h100, 16'h7F, 16'h100};

  always #50 mclk = ~mclk;

  escfg_regs i_escfg_regs (.mclk(mclk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .cdrRate(cdrRate), .scanDone(scanDone), .pointTime_ff(pointTime),
    .pointBudget_ff(pointBudget), .errorThresh_ff(errorThresh), .sliceLevel_ff(sliceLevel),
    .phaseBegin_ff(phaseBegin), .phaseLimit_ff(phaseLimit), .phaseStep_ff(phaseStep),
    .voltageBegin_ff(voltageBegin), .voltageLimit_ff(voltageLimit), .shapeMode_ff(shapeMode),
    .scanActive_ff(scanActive), .scannerInit_ff(scannerInit), .scannerPower_ff(scannerPower),
    .patternRate_ff(patternRate));

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one bus cycle; the request stays put until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {16'h0, wd};
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    rs = response;
    if (n >= 50) begin
      check("bus timeout", 32'h1, 32'h0);
      print_verdict();
    end
    read <= 1'b0;
    write <= 1'b0;
    // an idle edge keeps a following request from rewriting the strobes in the same step
    @(posedge mclk);
  endtask

  task automatic t_reset_vals;
    check("time", pointTime, 32'h64);
    check("budget", pointBudget, 32'hC8);
    check("thresh", {16'h0, errorThresh}, 32'h64);
    check("slice", {24'h0, sliceLevel}, 32'h80);
    check("rate", {29'h0, patternRate}, 32'h6);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, rIdx[i], 16'h0);
      check("reset word", rd, {16'h0, rVal[i]});
    end
    $display("done reset values");
  endtask

  task automatic t_rates;
    // the clock source field stays zero during the sweep, so the rate field sets each rate 1 through 4
    for (int c = 1; c <= 4; c++) begin
      bus(1'b1, 7'h52, 16'h0100 | 16'(c));
      repeat (2) @(posedge mclk);
      check("rate", {29'h0, patternRate}, 32'(c));
    end
    // recovered clock: the rate field must lose to the loop rate
    cdrRate <= 3'h4;
    bus(1'b1, 7'h52, 16'h01C1);
    repeat (2) @(posedge mclk);
    check("loop rate", {29'h0, patternRate}, 32'h4);
    cdrRate <= 3'h2;
    bus(1'b1, 7'h52, 16'h01C3);
    repeat (2) @(posedge mclk);
    check("loop rate", {29'h0, patternRate}, 32'h2);
    bus(1'b0, 7'h5E, 16'h0);
    check("rate status", rd, 32'h2);
    $display("done rates");
  endtask

  task automatic t_snapshot;
    bus(1'b1, 7'h54, 16'h0001);
    bus(1'b1, 7'h55, 16'hFFFF);
    bus(1'b1, 7'h56, 16'h1234);
    bus(1'b1, 7'h57, 16'hA506);
    bus(1'b1, 7'h5B, 16'h0205);
    // eye scan, powered, phase range and voltage limit left at reset
    bus(1'b1, 7'h5D, 16'h0003);
    repeat (2) @(posedge mclk);
    check("time", pointTime, 32'h0001FFFF);
    check("budget", pointBudget, 32'h0003FFFE);
    check("thresh", {16'h0, errorThresh}, 32'h1234);
    check("slice", {24'h0, sliceLevel}, 32'hA5);
    check("step vbegin", {scannerInit, shapeMode, scanActive, phaseStep, voltageBegin}, 32'h14105);
    check("ranges", {scannerPower, phaseBegin, phaseLimit, voltageLimit}, 32'h407FFF);
    // mid-scan edits land in the register but not in the snapshot
    bus(1'b1, 7'h55, 16'h0010);
    bus(1'b0, 7'h55, 16'h0);
    check("stored lower", rd, 32'h10);
    check("held time", pointTime, 32'h0001FFFF);
    scanDone <= 1'b1;
    @(posedge mclk);
    scanDone <= 1'b0;
    bus(1'b1, 7'h5D, 16'h0002);
    // shape capture wants the reset step
    bus(1'b1, 7'h5B, 16'h0100);
    bus(1'b1, 7'h5D, 16'h0103);
    repeat (2) @(posedge mclk);
    check("rescan", {shapeMode, scanActive, pointBudget[23:0]}, 32'h3020020);
    bus(1'b0, 7'h40, 16'h0);
    check("decode", {rs, rd[29:0]}, 32'hC0000000);
    $display("done snapshot");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset_vals();
    t_rates();
    t_snapshot();
    print_verdict();
  end
endmodule

// >>> src/escfg_cfg.svh
`ifndef ESCFG_CFG_SVH
`define ESCFG_CFG_SVH
// word indices; byte address is four times the index
`define ESC_IDX_GEN_CTRL    7'h52
`define ESC_IDX_RSVD53      7'h53
`define ESC_IDX_TIME_UPPER  7'h54
`define ESC_IDX_TIME_LOWER  7'h55
`define ESC_IDX_ERR_THRESH  7'h56
`define ESC_IDX_SLICE_INIT  7'h57
`define ESC_IDX_RSVD58      7'h58
`define ESC_IDX_RSVD59      7'h59
`define ESC_IDX_PHASE_RANGE 7'h5A
`define ESC_IDX_STEP_VSTART 7'h5B
`define ESC_IDX_VLIMIT      7'h5C
`define ESC_IDX_SCAN_CTRL   7'h5D
`define ESC_IDX_RATE_STATUS 7'h5E
// reset values
`define ESC_RST_GEN_CTRL    16'h0106
`define ESC_RST_ZERO        16'h0000
`define ESC_RST_TIME_LOWER  16'h0064
`define ESC_RST_ERR_THRESH  16'h0064
`define ESC_RST_SLICE_INIT  16'h8002
`define ESC_RST_RSVD58      16'hD982
`define ESC_RST_RSVD59      16'h0100
`define ESC_RST_PHASE_RANGE 16'h007F
`define ESC_RST_STEP_VSTART 16'h0100
`define ESC_RST_VLIMIT      16'hFF01
`define ESC_RST_RATE        3'h6
`define ESC_RST_SLICE       8'h80
`define ESC_RST_PSTART      7'h00
`define ESC_RST_PSTOP       7'h7F
`define ESC_RST_PSTEP       7'h01
`define ESC_RST_VSTART      7'h00
`define ESC_RST_VLIMIT_F    8'hFF
// field positions
`define ESC_F_RATE          2:0
`define ESC_F_CLKSRC        7:6
`define ESC_F_SLICE         15:8
`define ESC_B_INIT          2
`define ESC_F_PSTART        14:8
`define ESC_F_PSTOP         6:0
`define ESC_F_PSTEP         14:8
`define ESC_F_VSTART        6:0
`define ESC_F_VLIMIT        15:8
`define ESC_B_SHAPE         8
`define ESC_B_POWER         1
`define ESC_B_START         0
`define ESC_CLKSRC_RECOV    2'h3
`define ESC_TIME_SHIFT      1
`endif

// >>> src/escfg_pkg.sv
package escfg_pkg;
  typedef logic [15:0] escfg_word_t;
  typedef enum logic [2:0] {
    ESCFG_RATE_RSVD0, ESCFG_RATE_MADI, ESCFG_RATE_SD, ESCFG_RATE_HD,
    ESCFG_RATE_3G, ESCFG_RATE_RSVD5, ESCFG_RATE_RSVD6, ESCFG_RATE_RSVD7
  } escfg_rate_e;
  typedef enum {ESCFG_IDLE, ESCFG_BUSY, ESCFG_DONE} escfg_scan_e;
endpackage

// >>> src/escfg_rate_select.sv
`timescale 1ns/1ps
`include "escfg_cfg.svh"
// picks the rate the pattern generator actually runs at
module escfg_rate_select
  import escfg_pkg::*;
(
  // configuration
  input  wire logic [1:0] clockSource,
  input  wire logic [2:0] rateField,
  // recovery loop
  input  wire logic [2:0] cdrRate,
  // result
  output logic [2:0]      effRate
);
  // recovered clock source ignores the rate field
  always_comb begin
    if (clockSource == `ESC_CLKSRC_RECOV) begin
      effRate = cdrRate;
    end else begin
      effRate = rateField;
    end
  end
endmodule

// >>> src/escfg_regs.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "escfg_cfg.svh"
module escfg_regs
  import escfg_pkg::*;
#(
  parameter int AW = 9
)(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          resetn,
  // avalon-mm slave
  input  wire logic [AW-1:0] address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [31:0]   writedata,
  input  wire logic [3:0]    byteenable,
  output logic [31:0]        readdata,
  output logic               waitrequest,
  output logic [1:0]         response,
  // recovery loop and scanner hooks
  input  wire logic [2:0]    cdrRate,
  input  wire logic          scanDone,
  // configuration held for the scanner
  output logic [31:0]        pointTime_ff,
  output logic [31:0]        pointBudget_ff,
  output logic [15:0]        errorThresh_ff,
  output logic [7:0]         sliceLevel_ff,
  output logic [6:0]         phaseBegin_ff,
  output logic [6:0]         phaseLimit_ff,
  output logic [6:0]         phaseStep_ff,
  output logic [6:0]         voltageBegin_ff,
  output logic [7:0]         voltageLimit_ff,
  output logic               shapeMode_ff,
  output logic               scanActive_ff,
  output logic               scannerInit_ff,
  output logic               scannerPower_ff,
  // pattern generator
  output logic [2:0]         patternRate_ff
);
  // live register words
  escfg_word_t genCtrl_ff, timeUpper_ff, timeLower_ff, errThresh_ff, sliceInit_ff;
  escfg_word_t rsvd53_ff, rsvd58_ff, rsvd59_ff, phaseRange_ff, stepVstart_ff;
  escfg_word_t vLimit_ff, scanCtrl_ff;
  escfg_scan_e scanState_ff;
  logic [2:0]  effRate;
  logic [1:0]  phase_ff;
  logic [6:0]  wordIdx;
  logic        hit;
  logic        ackWr;
  logic [15:0] wmask;
  escfg_word_t rdWord;
  escfg_word_t nxt_rd;

  assign wordIdx = address[AW-1:2];
  assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // one wait state: phase 0 asserts wait, phase 1 completes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phase_ff <= 2'h0;
    end else if ((read || write) && phase_ff == 2'h0) begin
      phase_ff <= 2'h1;
    end else begin
      phase_ff <= 2'h0;
    end
  end

  assign ackWr = write && phase_ff == 2'h1;

  // waitrequest is registered: low only in the completing cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && phase_ff == 2'h0);
    end
  end

  // address decode into a word
  always_comb begin
    hit = 1'b1;
    nxt_rd = `ESC_RST_ZERO;
    case (wordIdx)
      `ESC_IDX_GEN_CTRL:    nxt_rd = genCtrl_ff;
      `ESC_IDX_RSVD53:      nxt_rd = rsvd53_ff;
      `ESC_IDX_TIME_UPPER:  nxt_rd = timeUpper_ff;
      `ESC_IDX_TIME_LOWER:  nxt_rd = timeLower_ff;
      `ESC_IDX_ERR_THRESH:  nxt_rd = errThresh_ff;
      `ESC_IDX_SLICE_INIT:  nxt_rd = sliceInit_ff;
      `ESC_IDX_RSVD58:      nxt_rd = rsvd58_ff;
      `ESC_IDX_RSVD59:      nxt_rd = rsvd59_ff;
      `ESC_IDX_PHASE_RANGE: nxt_rd = phaseRange_ff;
      `ESC_IDX_STEP_VSTART: nxt_rd = stepVstart_ff;
      `ESC_IDX_VLIMIT:      nxt_rd = vLimit_ff;
      `ESC_IDX_SCAN_CTRL:   nxt_rd = {scanCtrl_ff[15:3], scanActive_ff, scanCtrl_ff[1:0]};
      `ESC_IDX_RATE_STATUS: nxt_rd = {13'h0000, effRate};
      default:              hit = 1'b0;
    endcase
    rdWord = nxt_rd;
  end

  // read data and response launched with the waitrequest drop
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
      response <= 2'h0;
    end else if ((read || write) && phase_ff == 2'h0) begin
      readdata <= {16'h0000, read ? rdWord : 16'h0000};
      response <= hit ? 2'h0 : 2'h3; // unmapped answers decode error
    end
  end

  // software-writable words, byte enables honoured
  function automatic escfg_word_t merge(input escfg_word_t old, input escfg_word_t nw, input escfg_word_t m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // generator control: rate field, clock source and the rest of the word
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      genCtrl_ff <= `ESC_RST_GEN_CTRL;
    end else if (ackWr && wordIdx == `ESC_IDX_GEN_CTRL) begin
      genCtrl_ff <= merge(genCtrl_ff, writedata[15:0], wmask);
    end
  end

  // reserved word kept as plain storage so software reads back what it wrote
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rsvd53_ff <= `ESC_RST_ZERO;
    end else if (ackWr && wordIdx == `ESC_IDX_RSVD53) begin
      rsvd53_ff <= merge(rsvd53_ff, writedata[15:0], wmask);
    end
  end

  // upper half of the point time
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      timeUpper_ff <= `ESC_RST_ZERO;
    end else if (ackWr && wordIdx == `ESC_IDX_TIME_UPPER) begin
      timeUpper_ff <= merge(timeUpper_ff, writedata[15:0], wmask);
    end
  end

  // lower half of the point time; halves may be written apart, the snapshot joins them
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      timeLower_ff <= `ESC_RST_TIME_LOWER;
    end else if (ackWr && wordIdx == `ESC_IDX_TIME_LOWER) begin
      timeLower_ff <= merge(timeLower_ff, writedata[15:0], wmask);
    end
  end

  // error threshold for shape scans
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      errThresh_ff <= `ESC_RST_ERR_THRESH;
    end else if (ackWr && wordIdx == `ESC_IDX_ERR_THRESH) begin
      errThresh_ff <= merge(errThresh_ff, writedata[15:0], wmask);
    end
  end

  // default slice level and initialization bit
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sliceInit_ff <= `ESC_RST_SLICE_INIT;
    end else if (ackWr && wordIdx == `ESC_IDX_SLICE_INIT) begin
      sliceInit_ff <= merge(sliceInit_ff, writedata[15:0], wmask);
    end
  end

  // reserved word, plain storage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rsvd58_ff <= `ESC_RST_RSVD58;
    end else if (ackWr && wordIdx == `ESC_IDX_RSVD58) begin
      rsvd58_ff <= merge(rsvd58_ff, writedata[15:0], wmask);
    end
  end

  // reserved word, plain storage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rsvd59_ff <= `ESC_RST_RSVD59;
    end else if (ackWr && wordIdx == `ESC_IDX_RSVD59) begin
      rsvd59_ff <= merge(rsvd59_ff, writedata[15:0], wmask);
    end
  end

  // phase start and stop; range checks are left to software
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phaseRange_ff <= `ESC_RST_PHASE_RANGE;
    end else if (ackWr && wordIdx == `ESC_IDX_PHASE_RANGE) begin
      phaseRange_ff <= merge(phaseRange_ff, writedata[15:0], wmask);
    end
  end

  // phase step and voltage start
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stepVstart_ff <= `ESC_RST_STEP_VSTART;
    end else if (ackWr && wordIdx == `ESC_IDX_STEP_VSTART) begin
      stepVstart_ff <= merge(stepVstart_ff, writedata[15:0], wmask);
    end
  end

  // voltage limit word
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      vLimit_ff <= `ESC_RST_VLIMIT;
    end else if (ackWr && wordIdx == `ESC_IDX_VLIMIT) begin
      vLimit_ff <= merge(vLimit_ff, writedata[15:0], wmask);
    end
  end

  // scan control; the rate status word has no storage, so writes to it fall through
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scanCtrl_ff <= `ESC_RST_ZERO;
    end else if (ackWr && wordIdx == `ESC_IDX_SCAN_CTRL) begin
      scanCtrl_ff <= merge(scanCtrl_ff, writedata[15:0], wmask);
    end
  end

  // effective generator rate
  escfg_rate_select i_escfg_rate_select (
    .clockSource (genCtrl_ff[`ESC_F_CLKSRC]),
    .rateField   (genCtrl_ff[`ESC_F_RATE]),
    .cdrRate     (cdrRate),
    .effRate     (effRate)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      patternRate_ff <= `ESC_RST_RATE;
    end else begin
      patternRate_ff <= effRate;
    end
  end

  // static control bits follow their registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scannerInit_ff  <= 1'b0;
      scannerPower_ff <= 1'b0;
    end else begin
      scannerInit_ff  <= sliceInit_ff[`ESC_B_INIT];
      scannerPower_ff <= scanCtrl_ff[`ESC_B_POWER];
    end
  end

  // scan handshake: start level begins, done ends, start low rearms
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scanState_ff  <= ESCFG_IDLE;
      scanActive_ff <= 1'b0;
    end else begin
      case (scanState_ff)
        ESCFG_IDLE: begin
          if (scanCtrl_ff[`ESC_B_START]) begin
            scanState_ff  <= ESCFG_BUSY;
            scanActive_ff <= 1'b1;
          end
        end
        ESCFG_BUSY: begin
          if (scanDone) begin
            scanState_ff  <= ESCFG_DONE;
            scanActive_ff <= 1'b0;
          end
        end
        ESCFG_DONE: begin
          if (!scanCtrl_ff[`ESC_B_START]) begin
            scanState_ff <= ESCFG_IDLE;
          end
        end
        default: scanState_ff <= ESCFG_IDLE;
      endcase
    end
  end

  // snapshot when a scan starts so mid-scan writes cannot tear it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pointTime_ff    <= {`ESC_RST_ZERO, `ESC_RST_TIME_LOWER};
      pointBudget_ff  <= {`ESC_RST_ZERO, `ESC_RST_TIME_LOWER} << `ESC_TIME_SHIFT;
      errorThresh_ff  <= `ESC_RST_ERR_THRESH;
      sliceLevel_ff   <= `ESC_RST_SLICE;
      phaseBegin_ff   <= `ESC_RST_PSTART;
      phaseLimit_ff   <= `ESC_RST_PSTOP;
      phaseStep_ff    <= `ESC_RST_PSTEP;
      voltageBegin_ff <= `ESC_RST_VSTART;
      voltageLimit_ff <= `ESC_RST_VLIMIT_F;
      shapeMode_ff    <= 1'b0;
    end else if (scanState_ff == ESCFG_IDLE && scanCtrl_ff[`ESC_B_START]) begin
      pointTime_ff    <= {timeUpper_ff, timeLower_ff};
      pointBudget_ff  <= {timeUpper_ff, timeLower_ff} << `ESC_TIME_SHIFT;
      errorThresh_ff  <= errThresh_ff;
      sliceLevel_ff   <= sliceInit_ff[`ESC_F_SLICE];
      phaseBegin_ff   <= phaseRange_ff[`ESC_F_PSTART];
      phaseLimit_ff   <= phaseRange_ff[`ESC_F_PSTOP];
      phaseStep_ff    <= stepVstart_ff[`ESC_F_PSTEP];
      voltageBegin_ff <= stepVstart_ff[`ESC_F_VSTART];
      voltageLimit_ff <= vLimit_ff[`ESC_F_VLIMIT];
      shapeMode_ff    <= scanCtrl_ff[`ESC_B_SHAPE];
    end
  end
endmodule
